// ### verilog/sdram_pkg.sv
`default_nettype none
package sdram_pkg;
   // Link clock period, used to turn SDRAM timings into link cycles.
   localparam int LINK_PERIOD_NS = 32;
   // Least SDRAM timings in ns; each count rounds up, never below one.
   localparam int T_RCD_NS = 20;
   localparam int T_RP_NS  = 20;
   localparam int T_RC_NS  = 70;
   localparam int T_WR_NS  = 15;
   localparam int RCD_CYC = (T_RCD_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
   localparam int RP_CYC  = (T_RP_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
   localparam int RC_CYC  = (T_RC_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
   localparam int WR_CYC  = (T_WR_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
   // Refresh window and the largest row count it must cover.
   localparam int REF_WINDOW_MS = 64;
   localparam int REF_ROWS_MAX  = 8192;
   // Geometry bases: row width is 11 plus its select, column 8 plus its.
   localparam logic [4:0] ROW_BASE = 5'h0b;
   localparam logic [4:0] COL_BASE = 5'h08;
   localparam logic [1:0] SEL_MAX  = 2'h2;
   // Address pin index that doubles as the pre-charge command bit.
   localparam int AP_BIT = 10;
   // Read latencies selectable by the latency input.
   localparam logic [3:0] CAS_LAT_2 = 4'h2;
   localparam logic [3:0] CAS_LAT_3 = 4'h3;
   // Command codes as {row strobe, column strobe, write enable}, low true.
   localparam logic [2:0] CMD_NOP   = 3'h7;
   localparam logic [2:0] CMD_ACT   = 3'h3;
   localparam logic [2:0] CMD_READ  = 3'h5;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   localparam logic [2:0] CMD_PRE   = 3'h2;
   localparam logic [2:0] CMD_REF   = 3'h1;
   // Link-side sequencer states.
   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_RCD   = 7'h02,
      ST_DATA  = 7'h04,
      ST_RECOV = 7'h08,
      ST_SPARE = 7'h10
   } link_state_type;
endpackage : sdram_pkg
`default_nettype wire

// ### verilog/sdram_interface_16bit.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_interface_16bit
(
   // Core clock and synchronous reset.
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // SDRAM clock; the link logic runs on it.
   input  wire logic        i_link_clk,
   // Access request from the external bus controller.
   input  wire logic        i_req,
   input  wire logic        i_we,
   input  wire logic [25:0] i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic [1:0]  i_be,
   input  wire logic        i_area_three,
   output logic             o_busy,
   output logic             o_ack,
   output logic             o_err,
   output logic [15:0]      o_rdata,
   // Configuration levels, held steady while the block is in use.
   input  wire logic [1:0]  i_row_sel,
   input  wire logic [1:0]  i_col_sel,
   input  wire logic        i_cas_lat3,
   input  wire logic        i_auto_precharge,
   input  wire logic        i_area_two_en,
   input  wire logic        i_area_three_en,
   input  wire logic [15:0] i_ref_interval,
   // SDRAM pins.
   output logic             o_cke,
   output logic             o_chip_select_area_two_n,
   output logic             o_chip_select_area_three_n,
   output logic             o_row_strobe_lower_pair_n,
   output logic             o_column_strobe_lower_pair_n,
   output logic             o_row_strobe_upper_pair_n,
   output logic             o_column_strobe_upper_pair_n,
   output logic             o_we_n,
   output logic [14:0]      o_addr,
   output logic [1:0]       o_bank,
   output logic             o_byte_mask_lower,
   output logic             o_byte_mask_upper,
   output logic [15:0]      o_dq,
   output logic             o_dq_oe,
   input  wire logic [15:0] i_dq
);

   // Request held for the link while busy; stable until the answer returns.
   logic        busy_reg;
   logic        req_tgl_reg;
   logic        we_reg;
   logic [25:0] addr_reg;
   logic [15:0] wdata_reg;
   logic [1:0]  be_reg;
   logic        area3_reg;
   // Link-side answer toggle and read word; the core reads both.
   logic        ack_tgl_reg;
   logic [15:0] rdata_reg;
   // Answer toggle synchroniser, core side.
   logic        ack_s1_reg;
   logic        ack_s2_reg;
   logic        ack_s3_reg;
   logic        ack_edge;
   logic        area_ok;

   // The far toggle changed: the link finished the held request.
   assign ack_edge = ack_s2_reg ^ ack_s3_reg;
   // Requests to an area without SDRAM are refused at once.
   assign area_ok = i_area_three ? i_area_three_en : i_area_two_en;
   assign o_busy  = busy_reg;

   // Core side: take a request, flip the toggle, wait for the answer.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         busy_reg    <= 1'b0;
         req_tgl_reg <= 1'b0;
         we_reg      <= 1'b0;
         addr_reg    <= 26'h0000000;
         wdata_reg   <= 16'h0000;
         be_reg      <= 2'h0;
         area3_reg   <= 1'b0;
      end
      else if (!busy_reg && i_req && area_ok)
      begin
         busy_reg    <= 1'b1;
         req_tgl_reg <= ~req_tgl_reg;
         we_reg      <= i_we;
         addr_reg    <= i_addr;
         wdata_reg   <= i_wdata;
         be_reg      <= i_be;
         area3_reg   <= i_area_three;
      end
      else if (busy_reg && ack_edge)
      begin
         busy_reg <= 1'b0;
      end
   end

   // Answer pulses and read data; read data was settled before the toggle.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         ack_s1_reg <= 1'b0;
         ack_s2_reg <= 1'b0;
         ack_s3_reg <= 1'b0;
         o_ack      <= 1'b0;
         o_err      <= 1'b0;
         o_rdata    <= 16'h0000;
      end
      else
      begin
         ack_s1_reg <= ack_tgl_reg;
         ack_s2_reg <= ack_s1_reg;
         ack_s3_reg <= ack_s2_reg;
         o_ack <= (busy_reg && ack_edge) || (!busy_reg && i_req && !area_ok);
         o_err <= !busy_reg && i_req && !area_ok;
         if (busy_reg && ack_edge && !we_reg)
         begin
            o_rdata <= rdata_reg;
         end
      end
   end

   // Link domain: reset and configuration pass two flip-flops first.
   logic        lrst_s1_reg;
   logic        lrst_reg;
   logic [24:0] cfg_s1_reg;
   logic [24:0] cfg_reg;
   logic        rq_s1_reg;
   logic        rq_s2_reg;
   logic        pending;
   logic [4:0]  row_n;
   logic [4:0]  col_n;
   logic [3:0]  cas_lat;
   logic        ap_mode;
   logic        en2;
   logic        en3;
   logic [15:0] ref_ivl;

   always_ff @(posedge i_link_clk)
   begin
      lrst_s1_reg <= i_rst;
      lrst_reg    <= lrst_s1_reg;
      cfg_s1_reg  <= {i_row_sel, i_col_sel, i_cas_lat3, i_auto_precharge,
                      i_area_two_en, i_area_three_en, i_ref_interval, 1'b0};
      cfg_reg     <= cfg_s1_reg;
   end

   // Geometry selects above the largest code clamp to the largest.
   assign row_n = ROW_BASE_F(cfg_reg[24:23]);
   assign col_n = COL_BASE_F(cfg_reg[22:21]);
   assign cas_lat = cfg_reg[20] ? sdram_pkg::CAS_LAT_3
                                : sdram_pkg::CAS_LAT_2;
   assign ap_mode = cfg_reg[19];
   assign en2     = cfg_reg[18];
   assign en3     = cfg_reg[17];
   assign ref_ivl = cfg_reg[16:1];

   function automatic logic [4:0] ROW_BASE_F(input logic [1:0] s);
      ROW_BASE_F = sdram_pkg::ROW_BASE
                   + ((s > sdram_pkg::SEL_MAX) ? 5'(sdram_pkg::SEL_MAX) : 5'(s));
   endfunction : ROW_BASE_F

   function automatic logic [4:0] COL_BASE_F(input logic [1:0] s);
      COL_BASE_F = sdram_pkg::COL_BASE
                   + ((s > sdram_pkg::SEL_MAX) ? 5'(sdram_pkg::SEL_MAX) : 5'(s));
   endfunction : COL_BASE_F

   // Request toggle synchroniser; work waits while it differs from answer.
   always_ff @(posedge i_link_clk)
   begin
      if (lrst_reg)
      begin
         rq_s1_reg <= 1'b0;
         rq_s2_reg <= 1'b0;
      end
      else
      begin
         rq_s1_reg <= req_tgl_reg;
         rq_s2_reg <= rq_s1_reg;
      end
   end
   assign pending = rq_s2_reg ^ ack_tgl_reg;

   // Address multiplexing: row phase shifts the address down by the
   // column width plus one, so bank bits land just above the row bits.
   // The column phase carries the address up to the row width, so pins
   // beyond the column bits still follow the address, as the part expects.
   logic [25:0] row_shift;
   logic [14:0] row_word;
   logic [14:0] col_word;
   logic [1:0]  bank_bits;
   logic        is_512m;
   logic        use_lower;

   always_comb
   begin
      row_shift = addr_reg >> (col_n + 5'h01);
      row_word  = row_shift[14:0] & ~(15'h7fff << (row_n + 5'h02));
      bank_bits = 2'(row_word >> row_n);
      col_word  = (addr_reg[15:1] & ~(15'h7fff << row_n))
                  | (row_word & (15'h0003 << row_n));
      col_word[sdram_pkg::AP_BIT] = ap_mode;
   end

   // A 13-row, 10-column part uses bit 25 as a bank bit.
   assign is_512m   = (row_n == 5'h0d) && (col_n == 5'h0a);
   assign use_lower = is_512m || !addr_reg[25];

   // Refresh timer: interval in link cycles, zero stops refreshing.
   logic [15:0] ref_cnt_reg;
   logic        ref_pend_reg;
   logic        ref_issue;

   always_ff @(posedge i_link_clk)
   begin
      if (lrst_reg)
      begin
         ref_cnt_reg  <= 16'h0000;
         ref_pend_reg <= 1'b0;
      end
      else
      begin
         if (ref_ivl == 16'h0000 || ref_cnt_reg == 16'h0000)
         begin
            ref_cnt_reg <= ref_ivl;
         end
         else
         begin
            ref_cnt_reg <= ref_cnt_reg - 16'h0001;
         end
         // A new expiry in the issuing cycle wins over the clear.
         if (ref_ivl != 16'h0000 && ref_cnt_reg == 16'h0001)
         begin
            ref_pend_reg <= 1'b1;
         end
         else if (ref_issue)
         begin
            ref_pend_reg <= 1'b0;
         end
      end
   end

   // Sequencer and registered pins.
   sdram_pkg::link_state_type state_reg;
   logic [3:0]  cnt_reg;
   logic        srv_reg;
   logic [2:0]  cmd_reg;
   logic        sel2_reg;
   logic        sel3_reg;
   logic        sel_lo_reg;
   logic        sel_up_reg;

   assign ref_issue = (state_reg == sdram_pkg::ST_IDLE) && ref_pend_reg;

   always_ff @(posedge i_link_clk)
   begin
      if (lrst_reg)
      begin
         state_reg   <= sdram_pkg::ST_IDLE;
         cnt_reg     <= 4'h0;
         srv_reg     <= 1'b0;
         ack_tgl_reg <= 1'b0;
         cmd_reg     <= sdram_pkg::CMD_NOP;
         {sel2_reg, sel3_reg, sel_lo_reg, sel_up_reg} <= 4'h0;
         o_cke       <= 1'b0;
         o_addr      <= 15'h0000;
         o_bank      <= 2'h0;
         o_dq        <= 16'h0000;
         o_dq_oe     <= 1'b0;
         {o_byte_mask_upper, o_byte_mask_lower} <= 2'h3;
         rdata_reg   <= 16'h0000;
      end
      else
      begin
         o_cke   <= 1'b1;
         cmd_reg <= sdram_pkg::CMD_NOP;
         case (state_reg)
            sdram_pkg::ST_IDLE:
            begin
               // Refresh first: a late refresh may lose data.
               if (ref_pend_reg)
               begin
                  cmd_reg    <= sdram_pkg::CMD_REF;
                  sel2_reg   <= en2;
                  sel3_reg   <= en3;
                  sel_lo_reg <= 1'b1;
                  sel_up_reg <= 1'b1;
                  srv_reg    <= 1'b0;
                  cnt_reg    <= 4'(sdram_pkg::RC_CYC - 1);
                  state_reg  <= sdram_pkg::ST_RECOV;
               end
               else if (pending)
               begin
                  cmd_reg    <= sdram_pkg::CMD_ACT;
                  sel2_reg   <= !area3_reg;
                  sel3_reg   <= area3_reg;
                  sel_lo_reg <= use_lower;
                  sel_up_reg <= !use_lower;
                  o_addr     <= row_word;
                  o_bank     <= bank_bits;
                  srv_reg    <= 1'b1;
                  cnt_reg    <= 4'(sdram_pkg::RCD_CYC - 1);
                  state_reg  <= sdram_pkg::ST_RCD;
               end
               else
               begin
                  {sel2_reg, sel3_reg, sel_lo_reg, sel_up_reg} <= 4'h0;
               end
            end
            sdram_pkg::ST_RCD:
            begin
               if (cnt_reg == 4'h0)
               begin
                  // One word per command in either mode.
                  cmd_reg <= we_reg ? sdram_pkg::CMD_WRITE
                                    : sdram_pkg::CMD_READ;
                  o_addr  <= col_word;
                  o_dq    <= wdata_reg;
                  o_dq_oe <= we_reg;
                  o_byte_mask_lower <= we_reg ? !be_reg[0] : 1'b0;
                  o_byte_mask_upper <= we_reg ? !be_reg[1] : 1'b0;
                  cnt_reg <= we_reg ? 4'(sdram_pkg::WR_CYC) : cas_lat;
                  state_reg <= sdram_pkg::ST_DATA;
               end
               else
               begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            sdram_pkg::ST_DATA:
            begin
               o_dq_oe <= 1'b0;
               {o_byte_mask_upper, o_byte_mask_lower} <= 2'h3;
               if (cnt_reg == 4'h0)
               begin
                  if (!we_reg)
                  begin
                     rdata_reg <= i_dq;
                  end
                  // Without auto pre-charge, close all banks here.
                  if (!ap_mode)
                  begin
                     cmd_reg <= sdram_pkg::CMD_PRE;
                     o_addr[sdram_pkg::AP_BIT] <= 1'b1;
                  end
                  cnt_reg   <= 4'(sdram_pkg::RP_CYC - 1);
                  state_reg <= sdram_pkg::ST_RECOV;
               end
               else
               begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            sdram_pkg::ST_RECOV:
            begin
               if (cnt_reg == 4'h0)
               begin
                  if (srv_reg)
                  begin
                     ack_tgl_reg <= ~ack_tgl_reg;
                  end
                  srv_reg   <= 1'b0;
                  state_reg <= sdram_pkg::ST_IDLE;
               end
               else
               begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            default:
            begin
               state_reg <= sdram_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Row and column strobes combine the command with the pair chosen; chip selects follow the area, or the area enables on refresh.
   assign o_chip_select_area_two_n     = !sel2_reg;
   assign o_chip_select_area_three_n   = !sel3_reg;
   assign o_row_strobe_lower_pair_n    = cmd_reg[2] || !sel_lo_reg;
   assign o_column_strobe_lower_pair_n = cmd_reg[1] || !sel_lo_reg;
   assign o_row_strobe_upper_pair_n    = cmd_reg[2] || !sel_up_reg;
   assign o_column_strobe_upper_pair_n = cmd_reg[1] || !sel_up_reg;
   assign o_we_n                       = cmd_reg[0];

endmodule : sdram_interface_16bit
`default_nettype wire

// ### tb/sdram_interface_16bit_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_interface_16bit_sva
(
   // Link clock and reset.
   input wire logic        i_link_clk,
   input wire logic        i_rst,
   // Static configuration and request address.
   input wire logic [25:0] i_addr,
   input wire logic [1:0]  i_row_sel,
   input wire logic [1:0]  i_col_sel,
   input wire logic        i_auto_precharge,
   input wire logic        i_area_two_en,
   input wire logic        i_area_three_en,
   // Memory pins.
   input wire logic        o_chip_select_area_two_n,
   input wire logic        o_chip_select_area_three_n,
   input wire logic        o_row_strobe_lower_pair_n,
   input wire logic        o_column_strobe_lower_pair_n,
   input wire logic        o_row_strobe_upper_pair_n,
   input wire logic        o_column_strobe_upper_pair_n,
   input wire logic        o_we_n,
   input wire logic [14:0] o_addr,
   input wire logic [1:0]  o_bank,
   input wire logic        o_dq_oe
);
   // Both pairs merged; low-true strobes combine by AND.
   logic [2:0] cmd;
   logic       rw;
   assign cmd = {o_row_strobe_lower_pair_n & o_row_strobe_upper_pair_n,
                 o_column_strobe_lower_pair_n & o_column_strobe_upper_pair_n,
                 o_we_n};
   assign rw = cmd == sdram_pkg::CMD_READ || cmd == sdram_pkg::CMD_WRITE;
   default clocking @(posedge i_link_clk); endclocking
   default disable iff (i_rst);
   pair_apart_a: assert property (!o_row_strobe_lower_pair_n &&
      !o_row_strobe_upper_pair_n |-> cmd == sdram_pkg::CMD_REF)
      else $error("both pairs strobed outside refresh");
   upper_pick_a: assert property (!o_row_strobe_upper_pair_n &&
      cmd == sdram_pkg::CMD_ACT |->
      i_addr[25] && !(i_row_sel >= 2'h2 && i_col_sel >= 2'h2))
      else $error("upper pair chosen wrongly");
   act_then_rw_a: assert property (cmd == sdram_pkg::CMD_ACT |=>
      rw && $stable(o_bank)) else $error("activate not followed by access");
   ap_flag_a: assert property (rw |->
      o_addr[sdram_pkg::AP_BIT] == i_auto_precharge)
      else $error("pre-charge bit wrong");
   pre_follow_a: assert property (rw && !i_auto_precharge |->
      ##[1:8] cmd == sdram_pkg::CMD_PRE) else $error("no pre-charge");
   pre_all_a: assert property (cmd == sdram_pkg::CMD_PRE |->
      o_addr[sdram_pkg::AP_BIT]) else $error("pre-charge not all banks");
   area_gate_a: assert property (
      (o_chip_select_area_two_n || i_area_two_en) &&
      (o_chip_select_area_three_n || i_area_three_en))
      else $error("disabled area selected");
   ref_gap_a: assert property (cmd == sdram_pkg::CMD_REF |=>
      cmd == sdram_pkg::CMD_NOP [*2]) else $error("refresh gap short");
   dq_write_a: assert property (o_dq_oe |->
      cmd == sdram_pkg::CMD_WRITE) else $error("data driven off write");
endmodule : sdram_interface_16bit_sva
`default_nettype wire

// ### tb/sdram_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_model
(
   // Pins seen from the memory; two-bit pairs are {upper, lower}.
   input wire logic        i_link_clk,
   input wire logic        i_cas_lat3,
   input wire logic        i_sel_n,
   input wire logic [1:0]  i_ras_n,
   input wire logic [1:0]  i_cas_n,
   input wire logic        i_we_n,
   input wire logic [14:0] i_addr,
   input wire logic [1:0]  i_bank,
   input wire logic [1:0]  i_mask,
   input wire logic [15:0] i_dq_w,
   output logic [15:0]     o_dq
);
   logic [15:0] mem [logic [32:0]]; // Words keyed by pair, bank, row, col.
   logic [14:0] open_row [0:7];     // Open row of each pair and bank.
   logic [32:0] key;
   logic [15:0] word;
   logic [2:0]  cmd;
   logic        up;
   int          wait_cnt;
   initial
   begin
      o_dq = 16'h0000;
      wait_cnt = 0;
   end
   // Idle bus toggles each cycle so a late sample never hits a stale word.
   always @(posedge i_link_clk)
   begin
      up = !i_ras_n[1] || !i_cas_n[1];
      cmd = {&i_ras_n, &i_cas_n, i_we_n};
      key = {up, i_bank, open_row[{up, i_bank}], i_addr & 15'h7bff};
      if (wait_cnt == 1)
         o_dq <= word;
      else
         o_dq <= ~o_dq;
      if (wait_cnt > 0)
         wait_cnt--;
      if (!i_sel_n && cmd == sdram_pkg::CMD_ACT)
         open_row[{up, i_bank}] = i_addr;
      if (!i_sel_n && cmd == sdram_pkg::CMD_READ)
      begin
         word = mem.exists(key) ? mem[key] : 16'h0f0f;
         wait_cnt = i_cas_lat3 ? 2 : 1;
      end
      if (!i_sel_n && cmd == sdram_pkg::CMD_WRITE)
      begin
         word = mem.exists(key) ? mem[key] : 16'h0000;
         if (!i_mask[0])
            word[7:0] = i_dq_w[7:0];
         if (!i_mask[1])
            word[15:8] = i_dq_w[15:8];
         mem[key] = word;
      end
   end
endmodule : sdram_model
`default_nettype wire

// ### tb/test_sdram_interface_16bit.sv
`timescale 1ns/1ps
`default_nettype none
module test_sdram_interface_16bit;
   logic clk, lclk, rst, req, we, a3, cl3, ap, a2en, a3en;
   logic [25:0] addr;
   logic [15:0] wd, rint, rdata, dqo, dqi, got;
   logic [1:0] be, rsel, csel, bank, bnk_s, cs_s;
   logic [14:0] pa, row_s, col_s;
   logic busy, ack, err, cke, c2n, c3n, rl, cl, ru, cu, wen, ml, mu, oe;
   logic up_s, gerr;
   logic [2:0] c, msk_s;
   int n_errors, check_count, rb, cb, ref_cnt, act_cnt, n0, k;
   sdram_interface_16bit i_sdram_interface_16bit (.i_clk(clk), .i_rst(rst),
      .i_link_clk(lclk), .i_req(req), .i_we(we), .i_addr(addr),
      .i_wdata(wd), .i_be(be), .i_area_three(a3), .o_busy(busy),
      .o_ack(ack), .o_err(err), .o_rdata(rdata), .i_row_sel(rsel),
      .i_col_sel(csel), .i_cas_lat3(cl3), .i_auto_precharge(ap),
      .i_area_two_en(a2en), .i_area_three_en(a3en), .i_ref_interval(rint),
      .o_cke(cke), .o_chip_select_area_two_n(c2n),
      .o_chip_select_area_three_n(c3n), .o_row_strobe_lower_pair_n(rl),
      .o_column_strobe_lower_pair_n(cl), .o_row_strobe_upper_pair_n(ru),
      .o_column_strobe_upper_pair_n(cu), .o_we_n(wen), .o_addr(pa),
      .o_bank(bank), .o_byte_mask_lower(ml), .o_byte_mask_upper(mu),
      .o_dq(dqo), .o_dq_oe(oe), .i_dq(dqi));
   sdram_model i_sdram_model (.i_link_clk(lclk), .i_cas_lat3(cl3),
      .i_sel_n(c2n & c3n), .i_ras_n({ru, rl}), .i_cas_n({cu, cl}),
      .i_we_n(wen), .i_addr(pa), .i_bank(bank), .i_mask({mu, ml}),
      .i_dq_w(dqo), .o_dq(dqi));
   // Two unrelated clocks.
   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      lclk = 0;
      #3;
      forever #16 lclk = ~lclk;
   end
   // Pin monitor: remembers the last row and column phases seen.
   always @(posedge lclk)
   begin
      c = {rl & ru, cl & cu, wen};
      if (c == sdram_pkg::CMD_ACT)
      begin
         row_s = pa;
         bnk_s = bank;
         up_s = !ru;
         cs_s = {c2n, c3n};
         act_cnt++;
      end
      if (c == sdram_pkg::CMD_READ || c == sdram_pkg::CMD_WRITE)
         col_s = pa;
      if (c == sdram_pkg::CMD_WRITE)
         msk_s = {oe, mu, ml};
      if (c == sdram_pkg::CMD_REF)
         ref_cnt++;
   end
   task close_out;
      if (n_errors == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   task check_val(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : check_val
   // One request, raised for one core cycle, then wait until its acknowledge is seen.
   task access(input logic w, input logic [25:0] a, input logic [15:0] d,
               input logic [1:0] b);
      int n;
      while (busy)
         @(negedge clk);
      req = 1;
      we = w;
      addr = a;
      wd = d;
      be = b;
      @(negedge clk);
      req = 0;
      n = 0;
      while (!ack && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      check_val({15'h0, ack}, 16'h0001);
      gerr = err;
      got = rdata;
      check_val({15'h0, busy}, 16'h0000);
   endtask : access
   // Expected pin mapping worked out from the geometry.
   task check_map(input logic [25:0] a);
      check_val({1'b0, row_s}, 16'((a >> (cb + 1)) & ((26'h1 << (rb + 2)) - 1)));
      check_val({14'h0, bnk_s}, {14'h0, 2'(a >> (rb + cb + 1))});
      check_val(16'(col_s & ((26'h1 << cb) - 1)), 16'((a >> 1) & ((26'h1 << cb) - 1)));
      check_val({15'h0, col_s[10]}, {15'h0, ap});
      check_val({15'h0, up_s}, {15'h0, a[25] && !(rb == 13 && cb == 10)});
      check_val({14'h0, cs_s}, 16'h0002);
   endtask : check_map
   initial
   begin
      #500000;
      n_errors++;
      close_out();
   end
   // Addresses, data and geometry settings of the four passes.
   logic [25:0] base [4] = '{26'h2d6b5a4, 26'h3c97e38, 26'h1a53c6a,
                             26'h35a0f12};
   logic [15:0] dat [4] = '{16'hc3a5, 16'h5e71, 16'h9b2d, 16'h07f8};
   logic [5:0] cfg [4] = '{6'h14, 6'h2a, 6'h1b, 6'h00};
   initial
   begin
      {rst, req, we, addr, wd, be, cl3, ap, rsel, csel} = '1;
      {a3, a3en, a2en, rint} = {1'b1, 1'b1, 1'b0, 16'h0064};
      {n_errors, check_count, ref_cnt, act_cnt} = '0;
      req = 0;
      repeat (10) @(negedge clk);
      rst = 0;
      for (k = 0; k < 4; k++)
      begin
         {rsel, csel, cl3, ap} = cfg[k];
         repeat (20) @(negedge clk);
         rb = 11 + int'(rsel);
         cb = 8 + int'(csel);
         check_val({15'h0, cke}, 16'h0001);
         access(1, base[k], dat[k], 2'h3);
         check_map(base[k]);
         access(1, base[k], ~dat[k], 2'h1);
         check_val({13'h0, msk_s}, 16'h0006);
         access(0, base[k], 16'h0000, 2'h3);
         check_map(base[k]);
         check_val(got, {dat[k][15:8], ~dat[k][7:0]});
         check_val({15'h0, gerr}, 16'h0000);
      end
      n0 = act_cnt;
      a3 = 0;
      access(0, base[0], 16'h0000, 2'h3);
      check_val({15'h0, gerr}, 16'h0001);
      check_val(16'(act_cnt - n0), 16'h0000);
      n0 = ref_cnt;
      repeat (1000) @(posedge lclk);
      check_val({15'h0, (ref_cnt - n0) inside {[9:11]}}, 16'h0001);
      @(negedge clk);
      rint = 16'h0000;
      repeat (10) @(posedge lclk);
      n0 = ref_cnt;
      repeat (300) @(posedge lclk);
      check_val(16'(ref_cnt - n0), 16'h0000);
      close_out();
   end
endmodule : test_sdram_interface_16bit
bind sdram_interface_16bit sdram_interface_16bit_sva
   i_sdram_interface_16bit_sva (.*);
`default_nettype wire
